// ### boundary_scan_device.sv
// Behaviour
// - top data bit near input, serial-out first
// - low sixteen data pins: input, output cells
// - data bit zero control sets low pins
// - controller sets test straps before activity
// - four zero bits in shift-ir select extest
// - all-zero instruction routes chain, drives cells
// - controller enters shift-dr before chain data
// - controller shifts cells one bit per tck
// - tap advances on tck rise using tms
// - capture-ir loads fixed pattern 0001
// - control cell 0 input, 1 output
// - bypass and clamp use one-bit stage
`include "boundary_scan_regs.svh"

module boundary_scan_device
    import boundary_scan_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    scan_link.dev                  link,
    input  wire logic [`DB_W-1:0]  func_db_o,
    input  wire logic [`DB_W-1:0]  func_db_oe,
    input  wire logic              func_soz_o,
    input  wire logic [`DB_W-1:0]  db_i,
    output logic      [`DB_W-1:0]  db_o,
    output logic      [`DB_W-1:0]  db_oe,
    output logic                   soz_pin_o,
    output logic      [`DB_W-1:0]  core_db_i,
    output logic                   test_mode
);

    // chain positions counted from the output end
    function automatic int in_cell(input int k);
        if (k == 0)
            return `BSR_LOW_IN0;
        else if (k < `DB_LOW_N)
            return `BSR_LOW_BASE + 2 * (k - 1);
        else
            return `BSR_HIGH_BASE + 3 * (k - `DB_LOW_N);
    endfunction

    function automatic int out_cell(input int k);
        return (k == 0) ? `BSR_LOW_OUT0 : in_cell(k) + 1;
    endfunction

    function automatic int ctrl_cell(input int k);
        if (k < `DB_LOW_N)
            return `BSR_LOW_CTRL;
        else
            return in_cell(k) + 2;
    endfunction

    function automatic tap_state_t tap_next(input tap_state_t s,
                                            input logic       m);
        unique case (s)
            TLR:      return m ? TLR      : RTI;
            RTI:      return m ? SEL_DR   : RTI;
            SEL_DR:   return m ? SEL_IR   : CAP_DR;
            CAP_DR:   return m ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: return m ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: return m ? UPD_DR   : PAUSE_DR;
            PAUSE_DR: return m ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: return m ? UPD_DR   : SHIFT_DR;
            UPD_DR:   return m ? SEL_DR   : RTI;
            SEL_IR:   return m ? TLR      : CAP_IR;
            CAP_IR:   return m ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: return m ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: return m ? UPD_IR   : PAUSE_IR;
            PAUSE_IR: return m ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: return m ? UPD_IR   : SHIFT_IR;
            UPD_IR:   return m ? SEL_DR   : RTI;
        endcase
    endfunction

    logic [3:0]             lnk_s1_q;
    logic [3:0]             lnk_s2_q;
    logic [`STRAP_W-1:0]    strap_s1_q;
    logic [`STRAP_W-1:0]    strap_s2_q;
    logic [`DB_W-1:0]       db_s1_q;
    logic                   tck_prev_q;
    logic                   tck_s;
    logic                   tms_s;
    logic                   tdi_s;
    logic                   trst_n_s;
    logic                   tck_rise;
    logic                   tck_fall;
    tap_state_t             state_q;
    logic [`IR_W-1:0]       ir_sr_q;
    logic [`IR_W-1:0]       ir_q;
    logic [`BSR_LEN-1:0]    bsr_sr_q;
    logic [`BSR_LEN-1:0]    bsr_upd_q;
    logic [`BSR_LEN-1:0]    cap_v;
    logic                   byp_q;
    logic                   bsr_sel;
    logic                   drive_upd;
    logic                   tdo_q;
    logic                   tdo_oe_q;

    // two-stage capture of everything arriving from pins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lnk_s1_q   <= 4'h0;
            lnk_s2_q   <= 4'h0;
            strap_s1_q <= '0;
            strap_s2_q <= '0;
            db_s1_q    <= '0;
            core_db_i  <= '0;
            tck_prev_q <= 1'b0;
        end else begin
            lnk_s1_q   <= {link.tck, link.tms, link.tdi, link.trst_n};
            lnk_s2_q   <= lnk_s1_q;
            strap_s1_q <= link.straps;
            strap_s2_q <= strap_s1_q;
            db_s1_q    <= db_i;
            core_db_i  <= db_s1_q;
            tck_prev_q <= tck_s;
        end
    end

    assign tck_s    = lnk_s2_q[3];
    assign tms_s    = lnk_s2_q[2];
    assign tdi_s    = lnk_s2_q[1];
    assign trst_n_s = lnk_s2_q[0];
    assign tck_rise = tck_s & ~tck_prev_q;
    assign tck_fall = ~tck_s & tck_prev_q;

    always_ff @(posedge clk) begin
        if (sys_rst)
            test_mode <= 1'b0;
        else
            test_mode <= (strap_s2_q == `STRAP_TEST);
    end

    always_ff @(posedge clk) begin
        if (sys_rst || !trst_n_s || !test_mode)
            state_q <= TLR;
        else if (tck_rise)
            state_q <= tap_next(state_q, tms_s);
    end

    // instruction path
    always_ff @(posedge clk) begin
        if (sys_rst || state_q == TLR) begin
            ir_sr_q <= `IR_CAPTURE;
            ir_q    <= `IR_BYPASS;
        end else if (tck_rise && state_q == CAP_IR) begin
            ir_sr_q <= `IR_CAPTURE;
        end else if (tck_rise && state_q == SHIFT_IR) begin
            ir_sr_q <= {tdi_s, ir_sr_q[`IR_W-1:1]};
        end else if (tck_fall && state_q == UPD_IR) begin
            ir_q <= ir_sr_q;
        end
    end

    assign bsr_sel   = (ir_q == `IR_EXTEST) || (ir_q == `IR_SAMPLE);
    assign drive_upd = (ir_q == `IR_EXTEST) || (ir_q == `IR_CLAMP);

    always_comb begin
        cap_v = '0;
        cap_v[`BSR_SOZ_OUT]  = soz_pin_o;
        cap_v[`BSR_LOW_CTRL] = db_oe[0];
        for (int k = 0; k < `DB_W; k++) begin
            cap_v[in_cell(k)]  = core_db_i[k];
            cap_v[out_cell(k)] = db_o[k];
            if (k >= `DB_LOW_N)
                cap_v[ctrl_cell(k)] = db_oe[k];
        end
    end

    // data registers: chain shifts toward the serial-out cell
    always_ff @(posedge clk) begin
        if (sys_rst || state_q == TLR) begin
            bsr_sr_q  <= '0;
            bsr_upd_q <= '0;
            byp_q     <= 1'b0;
        end else if (tck_rise && state_q == CAP_DR) begin
            if (bsr_sel)
                bsr_sr_q <= cap_v;
            else
                byp_q <= 1'b0;
        end else if (tck_rise && state_q == SHIFT_DR) begin
            if (bsr_sel)
                bsr_sr_q <= {tdi_s, bsr_sr_q[`BSR_LEN-1:1]};
            else
                byp_q <= tdi_s;
        end else if (tck_fall && state_q == UPD_DR && bsr_sel) begin
            bsr_upd_q <= bsr_sr_q;
        end
    end

    // output line changes on the falling tck edge
    always_ff @(posedge clk) begin
        if (sys_rst || state_q == TLR) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe_q <= (state_q == SHIFT_IR) || (state_q == SHIFT_DR);
            if (state_q == SHIFT_IR)
                tdo_q <= ir_sr_q[0];
            else if (bsr_sel)
                tdo_q <= bsr_sr_q[0];
            else
                tdo_q <= byp_q;
        end
    end

    assign link.tdo_o  = tdo_q;
    assign link.tdo_oe = tdo_oe_q;

    // pin drivers, chain update register while its mode is on
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            db_o      <= '0;
            db_oe     <= '0;
            soz_pin_o <= 1'b0;
        end else if (drive_upd) begin
            soz_pin_o <= bsr_upd_q[`BSR_SOZ_OUT];
            for (int k = 0; k < `DB_W; k++) begin
                db_o[k]  <= bsr_upd_q[out_cell(k)];
                db_oe[k] <= bsr_upd_q[ctrl_cell(k)];
            end
        end else begin
            soz_pin_o <= func_soz_o;
            db_o      <= func_db_o;
            db_oe     <= func_db_oe;
        end
    end

endmodule

// ### boundary_scan_regs.svh
`ifndef BOUNDARY_SCAN_REGS_SVH
`define BOUNDARY_SCAN_REGS_SVH

`define CLK_PERIOD_NS   10
`define TCK_PERIOD_NS   80
`define TCK_HALF_CYC    ((`TCK_PERIOD_NS / 2) / `CLK_PERIOD_NS)
`define TCK_CNT_W       3

`define IR_W            4
`define IR_EXTEST       4'h0
`define IR_BYPASS       4'hF
`define IR_SAMPLE       4'hB
`define IR_CLAMP        4'h3
`define IR_CAPTURE      4'h1

`define DB_W            32
`define DB_LOW_N        16
`define BSR_LEN         82
`define BSR_SOZ_OUT     0
`define BSR_LOW_IN0     1
`define BSR_LOW_OUT0    2
`define BSR_LOW_CTRL    3
`define BSR_LOW_BASE    4
`define BSR_HIGH_BASE   34
`define STEP_W          7

`define STRAP_W         3
`define STRAP_TEST      3'h7

`define TRST_TICKS      2
`define RESET_TICKS     5
`define IN_TICKS        5
`define EXIT_TICKS      2
`define TMS_IR_IN       5'h06
`define TMS_DR_IN       5'h05
`define TMS_EXIT        2'h1

`endif

// ### boundary_scan_pkg.sv
package boundary_scan_pkg;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
        UPD_DR, SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR,
        UPD_IR
    } tap_state_t;

    typedef enum logic [2:0] {
        H_IDLE, H_TRST, H_RESET, H_IR_IN, H_IR_SHIFT, H_DR_IN, H_DR_SHIFT,
        H_EXIT
    } host_phase_t;

endpackage

// ### scan_link.sv
`include "boundary_scan_regs.svh"

interface scan_link;
    logic                  tck;
    logic                  tms;
    logic                  tdi;
    logic                  trst_n;
    logic [`STRAP_W-1:0]   straps;
    logic                  tdo_o;
    logic                  tdo_oe;
    logic                  tdo;

    // released line idles high
    assign tdo = tdo_oe ? tdo_o : 1'b1;

    modport dev (
        input  tck,
        input  tms,
        input  tdi,
        input  trst_n,
        input  straps,
        output tdo_o,
        output tdo_oe
    );

    modport host (
        output tck,
        output tms,
        output tdi,
        output trst_n,
        output straps,
        input  tdo
    );
endinterface

// ### boundary_scan_host.sv
`include "boundary_scan_regs.svh"

module boundary_scan_host
    import boundary_scan_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    scan_link.host                    link,
    input  wire logic                 start,
    input  wire logic [`IR_W-1:0]     instr,
    input  wire logic [`BSR_LEN-1:0]  chain_in,
    output logic      [`BSR_LEN-1:0]  chain_out,
    output logic                      busy,
    output logic                      done
);

    host_phase_t           phase_q;
    logic [`STEP_W-1:0]    step_q;
    logic [`TCK_CNT_W-1:0] cnt_q;
    logic                  tick_rise;
    logic                  tick_fall;
    logic                  tick_samp;
    logic                  last;
    logic                  tms_d;
    logic                  tdi_d;
    logic                  tck_q;
    logic                  tms_q;
    logic                  tdi_q;
    logic                  trst_n_q;
    logic                  samp_q;
    logic [`STRAP_W-1:0]   strap_q;
    logic [`IR_W-1:0]      instr_q;
    logic [`BSR_LEN-1:0]   data_q;
    logic                  tdo_s1_q;
    logic                  tdo_s2_q;

    // divider making tck: low half then high half
    assign tick_fall = busy && cnt_q == `TCK_CNT_W'(2 * `TCK_HALF_CYC - 1);
    assign tick_rise = busy && cnt_q == `TCK_CNT_W'(`TCK_HALF_CYC - 1);
    assign tick_samp = tick_fall;
    assign busy      = (phase_q != H_IDLE);

    always_ff @(posedge clk) begin
        if (sys_rst || !busy)
            cnt_q <= '0;
        else
            cnt_q <= cnt_q + `TCK_CNT_W'(1);
    end

    always_ff @(posedge clk) begin
        if (sys_rst || !busy)
            tck_q <= 1'b0;
        else if (tick_rise)
            tck_q <= 1'b1;
        else if (tick_fall)
            tck_q <= 1'b0;
    end

    always_comb begin
        last  = 1'b0;
        tms_d = 1'b1;
        tdi_d = 1'b0;
        unique case (phase_q)
            H_IDLE:     last = 1'b0;
            H_TRST:     last = (step_q == `STEP_W'(`TRST_TICKS - 1));
            H_RESET:    last = (step_q == `STEP_W'(`RESET_TICKS - 1));
            H_IR_IN: begin
                last  = (step_q == `STEP_W'(`IN_TICKS - 1));
                tms_d = 1'(`TMS_IR_IN >> step_q);
            end
            H_IR_SHIFT: begin
                last  = (step_q == `STEP_W'(`IR_W - 1));
                tms_d = last;
                tdi_d = instr_q[step_q[1:0]];
            end
            H_DR_IN: begin
                last  = (step_q == `STEP_W'(`IN_TICKS - 1));
                tms_d = 1'(`TMS_DR_IN >> step_q);
            end
            H_DR_SHIFT: begin
                last  = (step_q == `STEP_W'(`BSR_LEN - 1));
                tms_d = last;
                tdi_d = data_q[step_q];
            end
            H_EXIT: begin
                last  = (step_q == `STEP_W'(`EXIT_TICKS - 1));
                tms_d = 1'(`TMS_EXIT >> step_q);
            end
        endcase
    end

    // sequence of phases, advanced on each tck rise
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase_q <= H_IDLE;
            step_q  <= '0;
        end else if (!busy && start) begin
            phase_q <= H_TRST;
            step_q  <= '0;
        end else if (tick_rise) begin
            step_q <= last ? '0 : step_q + `STEP_W'(1);
            if (last)
                unique case (phase_q)
                    H_IDLE:     phase_q <= H_IDLE;
                    H_TRST:     phase_q <= H_RESET;
                    H_RESET:    phase_q <= H_IR_IN;
                    H_IR_IN:    phase_q <= H_IR_SHIFT;
                    H_IR_SHIFT: phase_q <= H_DR_IN;
                    H_DR_IN:    phase_q <= H_DR_SHIFT;
                    H_DR_SHIFT: phase_q <= H_EXIT;
                    H_EXIT:     phase_q <= H_IDLE;
                endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst)
            done <= 1'b0;
        else
            done <= tick_rise && last && phase_q == H_EXIT;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            instr_q <= `IR_BYPASS;
            data_q  <= '0;
        end else if (!busy && start) begin
            instr_q <= instr;
            data_q  <= chain_in;
        end
    end

    // straps set at start and held, before any tck activity
    always_ff @(posedge clk) begin
        if (sys_rst)
            strap_q <= '0;
        else if (!busy && start)
            strap_q <= `STRAP_TEST;
    end

    // tms and tdi change with tck falling, ahead of the rise
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tms_q    <= 1'b1;
            tdi_q    <= 1'b0;
            trst_n_q <= 1'b1;
        end else if (!busy && start) begin
            tms_q    <= 1'b1;
            tdi_q    <= 1'b0;
            trst_n_q <= 1'b0;
        end else if (tick_fall || !busy) begin
            tms_q    <= tms_d;
            tdi_q    <= tdi_d;
            trst_n_q <= (phase_q != H_TRST) || last;
        end
    end

    assign link.tck    = tck_q;
    assign link.tms    = tms_q;
    assign link.tdi    = tdi_q;
    assign link.trst_n = trst_n_q;
    assign link.straps = strap_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tdo_s1_q <= 1'b1;
            tdo_s2_q <= 1'b1;
        end else begin
            tdo_s1_q <= link.tdo;
            tdo_s2_q <= tdo_s1_q;
        end
    end

    // sample just before the next fall, after a shift-dr rise
    always_ff @(posedge clk) begin
        if (sys_rst || !busy)
            samp_q <= 1'b0;
        else if (tick_rise)
            samp_q <= (phase_q == H_DR_SHIFT);
    end

    always_ff @(posedge clk) begin
        if (sys_rst)
            chain_out <= '0;
        else if (tick_samp && samp_q)
            chain_out <= {tdo_s2_q, chain_out[`BSR_LEN-1:1]};
    end

endmodule

// ### boundary_scan_chain_access_monitor.sv
`include "boundary_scan_regs.svh"

module boundary_scan_chain_access_monitor
    import boundary_scan_pkg::*;
(
    input wire logic                clk,
    input wire logic                sys_rst,
    input wire logic                tck,
    input wire logic                tms,
    input wire logic                tdi,
    input wire logic                trst_n,
    input wire logic [`STRAP_W-1:0] straps,
    input wire logic                tdo_o,
    input wire logic                tdo_oe,
    input wire logic                tdo
);
    tap_state_t st_q;
    logic       tck_q;
    logic [6:0] rise_n_q;
    logic [6:0] fall_n_q;
    logic       in_shift;
    logic       in_ir_out;

    assign in_shift  = st_q == SHIFT_IR || st_q == SHIFT_DR;
    assign in_ir_out = st_q == SHIFT_IR || st_q == EXIT1_IR;

    function automatic tap_state_t next_st(tap_state_t s, logic m);
        case (s)
            TLR:              return m ? TLR : RTI;
            SEL_DR:           return m ? SEL_IR : CAP_DR;
            CAP_DR, SHIFT_DR: return m ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR:         return m ? UPD_DR : PAUSE_DR;
            PAUSE_DR:         return m ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR:         return m ? UPD_DR : SHIFT_DR;
            SEL_IR:           return m ? TLR : CAP_IR;
            CAP_IR, SHIFT_IR: return m ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR:         return m ? UPD_IR : PAUSE_IR;
            PAUSE_IR:         return m ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR:         return m ? UPD_IR : SHIFT_IR;
            default:          return m ? SEL_DR : RTI;
        endcase
    endfunction

    always_ff @(posedge clk) begin
        tck_q <= tck;
    end

    // mirror of the tap as the host drives it
    always_ff @(posedge clk) begin
        if (sys_rst || !trst_n || straps != `STRAP_TEST) begin
            st_q <= TLR;
        end else if (tck && !tck_q) begin
            st_q <= next_st(st_q, tms);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || st_q == CAP_IR || st_q == CAP_DR) begin
            rise_n_q <= 7'h00;
        end else if (tck && !tck_q && in_shift) begin
            rise_n_q <= rise_n_q + 7'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || st_q == CAP_IR) begin
            fall_n_q <= 7'h00;
        end else if (!tck && tck_q && in_ir_out) begin
            fall_n_q <= fall_n_q + 7'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence tck_rise_s;
        $rose(tck);
    endsequence

    sequence ir_fall_s;
        $fell(tck) && in_ir_out && fall_n_q != 7'h00;
    endsequence

    straps_set_a: assert property (
        tck_rise_s |-> straps == `STRAP_TEST)
        else $error("tck moved outside test mode");
    ir_capture_a: assert property (
        ir_fall_s |-> $past(tdo_oe) && $past(tdo) == $past(tdo_o)
        && $past(tdo) == (fall_n_q == 7'h01))
        else $error("instruction capture pattern wrong");
    ir_length_a: assert property (
        tck_rise_s ##0 (st_q == SHIFT_IR && tms) |-> rise_n_q == 7'h03)
        else $error("instruction shift not four bits");
    dr_length_a: assert property (
        tck_rise_s ##0 (st_q == SHIFT_DR && tms)
        |-> int'(rise_n_q) == `BSR_LEN - 1)
        else $error("data shift length wrong");
    dr_entry_a: assert property (
        tck_rise_s ##0 st_q == CAP_DR |-> !tms)
        else $error("shift state skipped");
    tms_on_fall_a: assert property (
        $changed(tms) |-> $fell(tck))
        else $error("tms changed away from tck fall");
    tdi_on_fall_a: assert property (
        $changed(tdi) |-> $fell(tck))
        else $error("tdi changed away from tck fall");
    tdo_drive_a: assert property (
        tdo_oe |-> in_shift || st_q == EXIT1_IR || st_q == EXIT1_DR)
        else $error("tdo driven outside shift");
    trst_release_a: assert property (
        !trst_n |-> ##[1:4] !tdo_oe)
        else $error("tdo still driven in test reset");
endmodule

// ### boundary_scan_chain_access_tb.sv
`include "boundary_scan_regs.svh"

module boundary_scan_chain_access_tb import boundary_scan_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [10:0] walk_bits = 11'h7D8;

    logic                clk;
    logic                sys_rst;
    logic                start;
    logic [`IR_W-1:0]    instr;
    logic [`BSR_LEN-1:0] chain_in;
    logic [`BSR_LEN-1:0] chain_out;
    logic                busy;
    logic                done;
    logic [`DB_W-1:0]    func_db_o;
    logic [`DB_W-1:0]    func_db_oe;
    logic                func_soz_o;
    logic [`DB_W-1:0]    db_i;
    logic [`DB_W-1:0]    db_o;
    logic [`DB_W-1:0]    db_oe;
    logic                soz_pin_o;
    logic [`DB_W-1:0]    core_db_i;
    logic                test_mode;
    logic                test_mode2;
    int                  failures;
    int                  check_count;

    scan_link scan_link_i ();
    scan_link scan_link_f ();

    boundary_scan_host boundary_scan_host_i (.clk(clk), .sys_rst(sys_rst),
        .link(scan_link_i.host), .start(start), .instr(instr),
        .chain_in(chain_in), .chain_out(chain_out), .busy(busy),
        .done(done));
    boundary_scan_device boundary_scan_device_i (.clk(clk),
        .sys_rst(sys_rst), .link(scan_link_i.dev), .func_db_o(func_db_o),
        .func_db_oe(func_db_oe), .func_soz_o(func_soz_o), .db_i(db_i),
        .db_o(db_o), .db_oe(db_oe), .soz_pin_o(soz_pin_o),
        .core_db_i(core_db_i), .test_mode(test_mode));
    boundary_scan_device boundary_scan_device_i2 (.clk(clk),
        .sys_rst(sys_rst), .link(scan_link_f.dev), .func_db_o(func_db_o),
        .func_db_oe(func_db_oe), .func_soz_o(func_soz_o), .db_i(db_i),
        .db_o(), .db_oe(), .soz_pin_o(), .core_db_i(),
        .test_mode(test_mode2));
    boundary_scan_chain_access_monitor boundary_scan_chain_access_monitor_i (
        .clk(clk), .sys_rst(sys_rst), .tck(scan_link_i.tck),
        .tms(scan_link_i.tms), .tdi(scan_link_i.tdi),
        .trst_n(scan_link_i.trst_n), .straps(scan_link_i.straps),
        .tdo_o(scan_link_i.tdo_o), .tdo_oe(scan_link_i.tdo_oe),
        .tdo(scan_link_i.tdo));

    always #5 clk = ~clk;

    function automatic int in_pos(int k);
        return (k == 0) ? 1 : (k < 16) ? 2 * k + 2 : 3 * k - 14;
    endfunction

    // pins expected once a chain image is applied
    function automatic logic [64:0] ext_pins(logic [81:0] c);
        logic [31:0] o;
        logic [31:0] e;
        for (int k = 0; k < 32; k++) begin
            o[k] = c[in_pos(k) + 1];
            e[k] = (k < 16) ? c[3] : c[in_pos(k) + 2];
        end
        return {c[0], e, o};
    endfunction

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("Checks: %0d, failures: %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // one 80 ns tck period on the spare link, tms set mid low phase
    task automatic bang(input logic m);
        repeat (2) @(posedge clk);
        #1 scan_link_f.tms = m;
        repeat (2) @(posedge clk);
        #1 scan_link_f.tck = 1'b1;
        repeat (4) @(posedge clk);
        #1 scan_link_f.tck = 1'b0;
    endtask

    task automatic run(input logic [3:0] ins, input logic [81:0] c);
        logic [63:0] pd;
        logic [31:0] gi;
        logic [31:0] go;
        int          moved;
        int          n;
        func_db_o  = $urandom;
        func_db_oe = $urandom;
        func_soz_o = 1'($urandom);
        db_i       = $urandom;
        instr      = ins;
        chain_in   = c;
        start      = 1'b1;
        @(posedge clk);
        #1 start = 1'b0;
        moved = 0;
        pd = {db_oe, db_o};
        for (n = 0; n < 2000 && done !== 1'b1; n++) begin
            @(posedge clk);
            #1;
            if (scan_link_i.tdo_oe === 1'b1 && {db_oe, db_o} !== pd) begin
                moved++;
            end
            pd = {db_oe, db_o};
        end
        if (done !== 1'b1) begin
            failures++;
            tally_and_finish;
        end
        check(128'(moved), 128'h0);
        check(128'({test_mode, busy, core_db_i}), 128'({2'h2, db_i}));
        for (int k = 0; k < 32; k++) begin
            gi[k] = chain_out[in_pos(k)];
            go[k] = chain_out[in_pos(k) + 1];
        end
        if (ins == `IR_EXTEST) begin
            check(128'(gi), 128'(db_i));
            check(128'({soz_pin_o, db_oe, db_o}), 128'(ext_pins(c)));
        end else if (ins == `IR_SAMPLE) begin
            check(128'({chain_out[0], go, gi, soz_pin_o, db_o}),
                128'({func_soz_o, func_db_o, db_i, func_soz_o,
                func_db_o}));
        end else begin
            check(128'(chain_out), 128'({c[80:0], 1'b0}));
            if (ins == `IR_CLAMP) begin
                check(128'({soz_pin_o, db_oe, db_o}), 128'h0);
            end
        end
    endtask

    initial begin
        logic [3:0]  tbl [6];
        logic [95:0] r;
        tbl = '{`IR_BYPASS, `IR_CLAMP, 4'h5, `IR_SAMPLE, `IR_EXTEST,
            `IR_EXTEST};
        clk = 1'b0;
        sys_rst = 1'b1;
        start = 1'b0;
        instr = 4'h0;
        chain_in = '0;
        func_db_o = 32'h0;
        func_db_oe = 32'h0;
        func_soz_o = 1'b0;
        db_i = 32'h0;
        scan_link_f.tck = 1'b0;
        scan_link_f.tms = 1'b1;
        scan_link_f.tdi = 1'b0;
        scan_link_f.trst_n = 1'b1;
        scan_link_f.straps = 3'h0;
        failures = 0;
        check_count = 0;
        void'($urandom(32'h70F0));
        repeat (4) @(posedge clk);
        #1 sys_rst = 1'b0;
        // spare device: straps off, then on; walk into shift-ir
        for (int k = 0; k < 2; k++) begin
            scan_link_f.straps = k ? `STRAP_TEST : 3'h0;
            scan_link_f.trst_n = 1'b1;
            repeat (5) @(posedge clk);
            #1 check(128'(test_mode2), 128'(k));
            for (int j = 10; j >= 0; j--) begin
                bang(walk_bits[j]);
            end
            repeat (5) @(posedge clk);
            #1 check(128'(scan_link_f.tdo), 128'(k == 0));
            scan_link_f.trst_n = 1'b0;
            repeat (6) @(posedge clk);
            #1 check(128'(scan_link_f.tdo), 128'h1);
        end
        for (int i = 0; i < 6; i++) begin
            r = {$urandom, $urandom, $urandom};
            if (i == 4) begin
                r = '1;
            end
            run(tbl[i], r[81:0]);
        end
        tally_and_finish;
    end
endmodule
